// >>> design/gxp_top.sv
// port 2 / port 3 pins with external interrupts and modulator output steering
//
// How it works
// - each pin direction follows its own direction bit: 0 input, 1 output
// - an output pin is driven from its port output latch
// - write strobe with pointer on a data register loads that port latch
// - latch bits keep their value until software writes them again
// - reading a data register returns the pin level of input pins
// - each pin has its own pull-up enable bit
// - an undriven input with pull-up enabled reads as one
// - port 2 bits 1 and 0 are also external interrupt lines one and zero
// - port 3 bits 1 and 0 are also external interrupt lines three and two
// - each external interrupt is gated by its own enable bit
// - trigger field 00 selects falling edge
// - trigger field 01 selects rising edge, 10 and 11 any change
// - port 2 bits 2 and 5 can carry the modulator outputs
// - each modulator enable bit decides if its output drives its pin
`timescale 1ns/10ps
`default_nettype none

module gxp_top
  import gxp_pkg::*;
#(
  parameter int unsigned PINS = gxp_pkg::NUM_PINS
)
(
  // clock, reset and clock enable
  input  wire logic                        CLK_I,
  input  wire logic                        RST_I,
  input  wire logic                        CE_I,
  // internal data bus
  input  wire logic [gxp_pkg::ADDR_W-1:0]  ADDR_I,
  input  wire logic [gxp_pkg::DATA_W-1:0]  WDATA_I,
  input  wire logic                        WR_I,
  input  wire logic                        RD_I,
  output logic      [gxp_pkg::DATA_W-1:0]  RDATA_O,
  // pins: input level, output value, output enable, pull-up enable
  input  wire logic [PINS-1:0]             PIN_IN_I,
  output logic      [PINS-1:0]             PIN_OUT_O,
  output logic      [PINS-1:0]             PIN_OE_O,
  output logic      [PINS-1:0]             PIN_PULLUP_O,
  // modulator outputs from the modulator block
  input  wire logic                        PDM1_I,
  input  wire logic                        PDM2_I,
  // request to the core and side controls
  output logic                             IRQ_O,
  output logic                             PROG_CNT_EN_O
);

  import gxp_pkg::*;

  // register state
  logic [DATA_W-1:0]  p2_data_q;
  logic [DATA_W-1:0]  p2_dir_q;
  logic [DATA_W-1:0]  p2_pu_q;
  logic [DATA_W-1:0]  p2_mode_q;
  logic [P3_W-1:0]    p3_data_q;
  logic [P3_W-1:0]    p3_dir_q;
  logic [P3_W-1:0]    p3_pu_q;
  logic [P3_W-1:0]    p3_mode_q;
  logic               prog_cnt_q;
  logic [NUM_IRQ-1:0] irq_en_q;
  logic               gie_q;
  logic [NUM_IRQ-1:0] pend_q;
  logic [NUM_IRQ-1:0] pend_d;
  logic [DATA_W-1:0]  rdata_q;
  logic [DATA_W-1:0]  rdata_d;

  // write decode
  logic wr_p2_data;
  logic wr_p2_dir;
  logic wr_p2_pu;
  logic wr_p2_mode;
  logic wr_p3_data;
  logic wr_p3_dir;
  logic wr_p3_pu;
  logic wr_p3_mode;
  logic wr_pend;
  logic wr_en;

  // per-pin views
  logic [PINS-1:0]    pin_dir;
  logic [PINS-1:0]    pin_latch;
  logic [PINS-1:0]    pin_pu;
  logic [PINS-1:0]    pin_level;
  logic [PINS-1:0]    pin_event;
  logic [1:0]         pin_mode [PINS];
  logic [PINS-1:0]    pdm_sel;
  logic [PINS-1:0]    pdm_val;
  logic [NUM_IRQ-1:0] irq_event;
  logic [DATA_W-1:0]  p2_view;
  logic [P3_W-1:0]    p3_view;

  // address decode: a write only lands while the pointer selects the register
  assign wr_p2_data = CE_I & WR_I & (ADDR_I == ADDR_P2_DATA);
  assign wr_p2_dir  = CE_I & WR_I & (ADDR_I == ADDR_P2_DIRECTION);
  assign wr_p2_pu   = CE_I & WR_I & (ADDR_I == ADDR_P2_PULLUP);
  assign wr_p2_mode = CE_I & WR_I & (ADDR_I == ADDR_P2_MODE);
  assign wr_p3_data = CE_I & WR_I & (ADDR_I == ADDR_P3_DATA);
  assign wr_p3_dir  = CE_I & WR_I & (ADDR_I == ADDR_P3_DIRECTION);
  assign wr_p3_pu   = CE_I & WR_I & (ADDR_I == ADDR_P3_PULLUP);
  assign wr_p3_mode = CE_I & WR_I & (ADDR_I == ADDR_P3_MODE);
  assign wr_pend    = CE_I & WR_I & (ADDR_I == ADDR_IRQ_PENDING);
  assign wr_en      = CE_I & WR_I & (ADDR_I == ADDR_IRQ_ENABLES);

  // port 2 output latch; content after reset is not to be relied on
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      p2_data_q <= RST_BYTE;
    else if (wr_p2_data)
      p2_data_q <= WDATA_I;
  end

  // port 3 output latch, low nibble only
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      p3_data_q <= RST_NIB;
    else if (wr_p3_data)
      p3_data_q <= WDATA_I[P3_W-1:0];
  end

  // port 2 direction
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      p2_dir_q <= RST_BYTE;
    else if (wr_p2_dir)
      p2_dir_q <= WDATA_I;
  end

  // port 3 direction
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      p3_dir_q <= RST_NIB;
    else if (wr_p3_dir)
      p3_dir_q <= WDATA_I[P3_W-1:0];
  end

  // port 2 pull-up enables
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      p2_pu_q <= RST_BYTE;
    else if (wr_p2_pu)
      p2_pu_q <= WDATA_I;
  end

  // port 3 pull-up enables
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      p3_pu_q <= RST_NIB;
    else if (wr_p3_pu)
      p3_pu_q <= WDATA_I[P3_W-1:0];
  end

  // port 2 mode: trigger fields for lines 0 and 1, modulator enables
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      p2_mode_q <= RST_BYTE;
    else if (wr_p2_mode)
      p2_mode_q <= WDATA_I;
  end

  // port 3 mode: trigger fields for lines 2 and 3
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      p3_mode_q <= RST_NIB;
    else if (wr_p3_mode)
      p3_mode_q <= WDATA_I[P3_W-1:0];
  end

  // counter enable bit shares the port 3 mode register; only stored and passed out
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      prog_cnt_q <= 1'b0;
    else if (wr_p3_mode)
      prog_cnt_q <= WDATA_I[PROG_CNT_BIT];
  end

  // interrupt enables and global enable
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      irq_en_q <= '0;
      gie_q    <= 1'b0;
    end
    else if (wr_en)
    begin
      irq_en_q <= WDATA_I[NUM_IRQ-1:0];
      gie_q    <= WDATA_I[GIE_BIT];
    end
  end

  // map register bits onto the pin vector
  always_comb
  begin
    pin_dir[PIN_P2_0]   = p2_dir_q[BIT_0];
    pin_dir[PIN_P2_1]   = p2_dir_q[BIT_1];
    pin_dir[PIN_P2_2]   = p2_dir_q[BIT_2];
    pin_dir[PIN_P2_5]   = p2_dir_q[BIT_5];
    pin_dir[PIN_P3_0]   = p3_dir_q[BIT_0];
    pin_dir[PIN_P3_1]   = p3_dir_q[BIT_1];
    pin_latch[PIN_P2_0] = p2_data_q[BIT_0];
    pin_latch[PIN_P2_1] = p2_data_q[BIT_1];
    pin_latch[PIN_P2_2] = p2_data_q[BIT_2];
    pin_latch[PIN_P2_5] = p2_data_q[BIT_5];
    pin_latch[PIN_P3_0] = p3_data_q[BIT_0];
    pin_latch[PIN_P3_1] = p3_data_q[BIT_1];
    pin_pu[PIN_P2_0]    = p2_pu_q[BIT_0];
    pin_pu[PIN_P2_1]    = p2_pu_q[BIT_1];
    pin_pu[PIN_P2_2]    = p2_pu_q[BIT_2];
    pin_pu[PIN_P2_5]    = p2_pu_q[BIT_5];
    pin_pu[PIN_P3_0]    = p3_pu_q[BIT_0];
    pin_pu[PIN_P3_1]    = p3_pu_q[BIT_1];
  end

  // trigger fields; pins without an interrupt line keep falling mode, event unused
  always_comb
  begin
    pin_mode[PIN_P2_0] = p2_mode_q[TRIG_LO_SEL_LSB +: 2];
    pin_mode[PIN_P2_1] = p2_mode_q[TRIG_HI_SEL_LSB +: 2];
    pin_mode[PIN_P2_2] = TRIG_FALL;
    pin_mode[PIN_P2_5] = TRIG_FALL;
    pin_mode[PIN_P3_0] = p3_mode_q[TRIG_LO_SEL_LSB +: 2];
    pin_mode[PIN_P3_1] = p3_mode_q[TRIG_HI_SEL_LSB +: 2];
  end

  // modulator steering: only port 2 bits 2 and 5 can be taken over
  always_comb
  begin
    pdm_sel           = '0;
    pdm_val           = '0;
    pdm_sel[PIN_P2_2] = p2_mode_q[PDM1_EN_BIT];
    pdm_sel[PIN_P2_5] = p2_mode_q[PDM2_EN_BIT];
    pdm_val[PIN_P2_2] = PDM1_I;
    pdm_val[PIN_P2_5] = PDM2_I;
  end

  // per-pin input path and pad controls
  genvar g;
  generate
    for (g = 0; g < PINS; g++)
    begin : g_pin
      gxp_pin_in u_in (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .ce_i    (CE_I),
        .pin_i   (PIN_IN_I[g]),
        .mode_i  (pin_mode[g]),
        .level_o (pin_level[g]),
        .event_o (pin_event[g])
      );

      // the pad resolves the pulled-up level; we only switch the resistor
      assign PIN_PULLUP_O[g] = pin_pu[g];
      // modulator wins over the latch and forces the driver on
      assign PIN_OE_O[g]     = pin_dir[g] | pdm_sel[g];
      assign PIN_OUT_O[g]    = pdm_sel[g] ? pdm_val[g] : pin_latch[g];
    end
  endgenerate

  // interrupt line order: lines 0,1 on port 2, lines 2,3 on port 3
  assign irq_event = {pin_event[PIN_P3_1], pin_event[PIN_P3_0],
                      pin_event[PIN_P2_1], pin_event[PIN_P2_0]};

  // pending flags: write 0 clears, write 1 keeps; a new event beats the clear
  always_comb
  begin
    pend_d = pend_q;
    if (wr_pend)
      pend_d = pend_q & WDATA_I[NUM_IRQ-1:0];
    pend_d = pend_d | irq_event;
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      pend_q <= '0;
    else if (CE_I)
      pend_q <= pend_d;
  end

  // flags latch even when masked, so enabling later raises a request at once
  assign IRQ_O         = gie_q & |(pend_q & irq_en_q);
  assign PROG_CNT_EN_O = prog_cnt_q;

  // data read view: input pins and modulator-driven pins show their synchronised level, other outputs the latch
  always_comb
  begin
    p2_view = p2_data_q;
    p3_view = p3_data_q;
    if (!p2_dir_q[BIT_0])
      p2_view[BIT_0] = pin_level[PIN_P2_0];
    if (!p2_dir_q[BIT_1])
      p2_view[BIT_1] = pin_level[PIN_P2_1];
    if (!p2_dir_q[BIT_2] || p2_mode_q[PDM1_EN_BIT])
      p2_view[BIT_2] = pin_level[PIN_P2_2];
    if (!p2_dir_q[BIT_5] || p2_mode_q[PDM2_EN_BIT])
      p2_view[BIT_5] = pin_level[PIN_P2_5];
    if (!p3_dir_q[BIT_0])
      p3_view[BIT_0] = pin_level[PIN_P3_0];
    if (!p3_dir_q[BIT_1])
      p3_view[BIT_1] = pin_level[PIN_P3_1];
  end

  // read mux; unmapped pointer values and unimplemented bits read zero
  always_comb
  begin
    rdata_d = RST_BYTE;
    unique case (ADDR_I)
      ADDR_IRQ_PENDING:  rdata_d[NUM_IRQ-1:0] = pend_q;
      ADDR_IRQ_ENABLES:
      begin
        rdata_d[NUM_IRQ-1:0] = irq_en_q;
        rdata_d[GIE_BIT]     = gie_q;
      end
      ADDR_P2_DATA:      rdata_d = p2_view;
      ADDR_P2_DIRECTION: rdata_d = p2_dir_q;
      ADDR_P2_PULLUP:    rdata_d = p2_pu_q;
      ADDR_P2_MODE:      rdata_d = p2_mode_q;
      ADDR_P3_DATA:      rdata_d[P3_W-1:0] = p3_view;
      ADDR_P3_DIRECTION: rdata_d[P3_W-1:0] = p3_dir_q;
      ADDR_P3_PULLUP:    rdata_d[P3_W-1:0] = p3_pu_q;
      ADDR_P3_MODE:
      begin
        rdata_d[P3_W-1:0]    = p3_mode_q;
        rdata_d[PROG_CNT_BIT] = prog_cnt_q;
      end
      default:           rdata_d = RST_BYTE;
    endcase
  end

  // read data is registered; it holds until the next read strobe
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      rdata_q <= RST_BYTE;
    else if (CE_I && RD_I)
      rdata_q <= rdata_d;
  end

  assign RDATA_O = rdata_q;

endmodule : gxp_top

`default_nettype wire

// >>> pkg/gxp_pkg.sv
// constants for the port 2 / port 3 pin and external interrupt block
`default_nettype none

package gxp_pkg;

  // data bus and address pointer widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;

  // register offsets on the internal address pointer
  localparam logic [7:0] ADDR_IRQ_PENDING  = 8'h06;
  localparam logic [7:0] ADDR_IRQ_ENABLES  = 8'h07;
  localparam logic [7:0] ADDR_P2_DATA      = 8'h24;
  localparam logic [7:0] ADDR_P2_DIRECTION = 8'h25;
  localparam logic [7:0] ADDR_P2_PULLUP    = 8'h26;
  localparam logic [7:0] ADDR_P2_MODE      = 8'h27;
  localparam logic [7:0] ADDR_P3_DATA      = 8'h28;
  localparam logic [7:0] ADDR_P3_DIRECTION = 8'h29;
  localparam logic [7:0] ADDR_P3_PULLUP    = 8'h2a;
  localparam logic [7:0] ADDR_P3_MODE      = 8'h2b;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIB  = 4'h0;
  localparam logic [1:0] RST_TRIG = 2'h0;

  // port 3 registers implement only the low nibble, apart from the counter enable at bit 4 of the mode register
  localparam int unsigned P3_W = 4;

  // external interrupt count and field positions
  localparam int unsigned NUM_IRQ        = 4;
  localparam int unsigned GIE_BIT        = 7;
  localparam int unsigned PDM1_EN_BIT    = 4;
  localparam int unsigned PDM2_EN_BIT    = 5;
  localparam int unsigned PROG_CNT_BIT   = 4;
  localparam int unsigned TRIG_LO_SEL_LSB = 0;
  localparam int unsigned TRIG_HI_SEL_LSB = 2;

  // trigger mode encodings
  localparam logic [1:0] TRIG_FALL = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_ANY0 = 2'h2;
  localparam logic [1:0] TRIG_ANY1 = 2'h3;

  // pin vector layout: which port bit each pin index carries
  localparam int unsigned NUM_PINS = 6;
  localparam int unsigned PIN_P2_0 = 0;
  localparam int unsigned PIN_P2_1 = 1;
  localparam int unsigned PIN_P2_2 = 2;
  localparam int unsigned PIN_P2_5 = 3;
  localparam int unsigned PIN_P3_0 = 4;
  localparam int unsigned PIN_P3_1 = 5;
  localparam int unsigned BIT_0    = 0;
  localparam int unsigned BIT_1    = 1;
  localparam int unsigned BIT_2    = 2;
  localparam int unsigned BIT_5    = 5;

  // input qualification: cycles after reset before edges count
  localparam logic [1:0] PRIME_CYCLES = 2'h3;

endpackage : gxp_pkg

`default_nettype wire

// >>> design/gxp_pin_in.sv
// input synchroniser and trigger-mode edge detector for one pin
`timescale 1ns/10ps
`default_nettype none

module gxp_pin_in
  import gxp_pkg::*;
(
  // clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // pin and trigger selection
  input  wire logic       pin_i,
  input  wire logic [1:0] mode_i,
  // synchronised level and one-cycle event
  output logic            level_o,
  output logic            event_o
);

  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  logic [1:0] prime_q;
  logic       rise;
  logic       fall;

  // two-flop synchroniser; sync1_q feeds sync2_q only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  // previous synchronised level for edge compare
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_q <= 1'b0;
    else if (ce_i)
      prev_q <= sync2_q;
  end

  // hold off edges until the chain holds real pin data, avoiding a false edge at release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prime_q <= 2'h0;
    else if (ce_i && prime_q != PRIME_CYCLES)
      prime_q <= prime_q + 2'h1;
  end

  assign rise    = sync2_q & ~prev_q;
  assign fall    = ~sync2_q & prev_q;
  assign level_o = sync2_q;

  // trigger selection; one event per synchronised edge
  always_comb
  begin
    event_o = 1'b0;
    if (ce_i && prime_q == PRIME_CYCLES)
    begin
      unique case (mode_i)
        TRIG_FALL: event_o = fall;
        TRIG_RISE: event_o = rise;
        TRIG_ANY0: event_o = rise | fall;
        TRIG_ANY1: event_o = rise | fall;
      endcase
    end
  end

endmodule : gxp_pin_in

`default_nettype wire

// >>> bench/gxp_properties.sv
// assertions on the pin, register and interrupt behaviour of gxp_top
`timescale 1ns/10ps
`default_nettype none

module gxp_properties
  import gxp_pkg::*;
#(
  parameter int unsigned PINS = 6
)
(
  // clock, reset and bus
  input wire logic              CLK_I,
  input wire logic              RST_I,
  input wire logic              CE_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic              WR_I,
  input wire logic              RD_I,
  input wire logic [DATA_W-1:0] RDATA_O,
  // pins and side outputs
  input wire logic [PINS-1:0]   PIN_OUT_O,
  input wire logic [PINS-1:0]   PIN_OE_O,
  input wire logic [PINS-1:0]   PIN_PULLUP_O,
  input wire logic              PDM1_I,
  input wire logic              PDM2_I,
  input wire logic              IRQ_O,
  input wire logic              PROG_CNT_EN_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // strobes only count while the clock enable is high
  wire logic wr = CE_I && WR_I;
  wire logic rd = CE_I && RD_I;

  chk_reset_clears: assert property ($fell(RST_I) |-> !PIN_OE_O && !PIN_PULLUP_O && !IRQ_O)
    else $error("outputs not clear after reset");
  chk_p2_dir_oe: assert property (
    wr && ADDR_I == ADDR_P2_DIRECTION |=> PIN_OE_O[1:0] == $past(WDATA_I[1:0]))
    else $error("port 2 enable does not follow direction");
  chk_p3_dir_oe: assert property (
    wr && ADDR_I == ADDR_P3_DIRECTION |=> PIN_OE_O[5:4] == $past(WDATA_I[1:0]))
    else $error("port 3 enable does not follow direction");
  chk_pullup_map: assert property (
    wr && ADDR_I == ADDR_P2_PULLUP |=>
      PIN_PULLUP_O[3:0] == $past({WDATA_I[5], WDATA_I[2:0]}))
    else $error("pull-up enables wrong");
  chk_latch_drive: assert property (
    wr && ADDR_I == ADDR_P2_DATA |=> PIN_OUT_O[1:0] == $past(WDATA_I[1:0]))
    else $error("latch not on pins");
  // the latch must not move without a data write, whatever else is written
  chk_latch_hold: assert property (
    !(wr && (ADDR_I == ADDR_P2_DATA || ADDR_I == ADDR_P3_DATA)) |=>
      $stable({PIN_OUT_O[5:4], PIN_OUT_O[1:0]}))
    else $error("latch changed without write");
  chk_mod1_steer: assert property (
    wr && ADDR_I == ADDR_P2_MODE && WDATA_I[4] |=> PIN_OE_O[2] && PIN_OUT_O[2] == PDM1_I)
    else $error("modulator 1 not on its pin");
  chk_mod2_steer: assert property (
    wr && ADDR_I == ADDR_P2_MODE && WDATA_I[5] |=> PIN_OE_O[3] && PIN_OUT_O[3] == PDM2_I)
    else $error("modulator 2 not on its pin");
  chk_irq_gated: assert property (
    wr && ADDR_I == ADDR_IRQ_ENABLES && (!WDATA_I[7] || !WDATA_I[3:0]) |=> !IRQ_O)
    else $error("request without enable");
  chk_cnt_enable: assert property (
    wr && ADDR_I == ADDR_P3_MODE |=> PROG_CNT_EN_O == $past(WDATA_I[4]))
    else $error("counter enable wrong");
  chk_rdata_holds: assert property (!rd |=> $stable(RDATA_O))
    else $error("read data moved without read");
  chk_unmapped_zero: assert property (rd && ADDR_I == 8'h3f |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");

  cover property (rd && ADDR_I == ADDR_P2_DATA);
  cover property ($rose(IRQ_O));
  cover property (wr && ADDR_I == ADDR_P2_MODE && WDATA_I[5:4] == 2'h3);
endmodule : gxp_properties

bind gxp_top gxp_properties #(.PINS(PINS)) u_props (
  .CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PIN_OUT_O(PIN_OUT_O), .PIN_OE_O(PIN_OE_O),
  .PIN_PULLUP_O(PIN_PULLUP_O), .PDM1_I(PDM1_I), .PDM2_I(PDM2_I), .IRQ_O(IRQ_O),
  .PROG_CNT_EN_O(PROG_CNT_EN_O));

`default_nettype wire

// >>> bench/gxp_pads.sv
// pad model: resolves each pin from the block driver, an outside driver and the pull-up
`timescale 1ns/10ps
`default_nettype none

module gxp_pads #(
  parameter int unsigned PINS = 6
)
(
  // clock for the floating pattern
  input  wire logic            clk_i,
  // block side
  input  wire logic [PINS-1:0] out_i,
  input  wire logic [PINS-1:0] oe_i,
  input  wire logic [PINS-1:0] pu_i,
  // outside driver
  input  wire logic [PINS-1:0] ext_val_i,
  input  wire logic [PINS-1:0] ext_en_i,
  // level seen by the block
  output logic      [PINS-1:0] level_o
);
  logic [PINS-1:0] float_q = '0;

  // an open pin wanders every cycle, so nothing can lean on a stale level
  always @(posedge clk_i)
    float_q <= ~float_q;

  // block driver first; it wins over the bench driver when both drive a pin
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
    begin
      if (oe_i[i])
        level_o[i] = out_i[i];
      else if (ext_en_i[i])
        level_o[i] = ext_val_i[i];
      else if (pu_i[i])
        level_o[i] = 1'b1;
      else
        level_o[i] = float_q[i];
    end
  end
endmodule : gxp_pads

`default_nettype wire

// >>> bench/test_gxp_top.sv
// self-checking bench for the port pins, modulator steering and external interrupts
`timescale 1ns/10ps
`default_nettype none

module test_gxp_top;
  import gxp_pkg::*;

  // design ports, pad drive and bench state
  logic        CLK_I, RST_I, CE_I, WR_I, RD_I, PDM1_I, PDM2_I, IRQ_O, PROG_CNT_EN_O;
  logic [7:0]  ADDR_I, WDATA_I, RDATA_O, d, e2, e3, m2, m3, g;
  logic [5:0]  PIN_IN_I, PIN_OUT_O, PIN_OE_O, PIN_PULLUP_O, ext_val, ext_en;
  logic [31:0] seed = 32'h000155e5;
  int          fail_count = 0;
  int          num_checks = 0;
  // bench model of the plain read/write registers, keyed by pointer value
  int          model [int];
  // register table with implemented bits, and port bit of each pin
  logic [7:0]  adr [8] = '{ADDR_IRQ_PENDING, ADDR_IRQ_ENABLES, ADDR_P2_DIRECTION, ADDR_P2_PULLUP,
                           ADDR_P2_MODE, ADDR_P3_DIRECTION, ADDR_P3_PULLUP, ADDR_P3_MODE};
  logic [7:0]  msk [8] = '{8'h0f, 8'h8f, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h0f, 8'h1f};
  int          pb [6] = '{0, 1, 2, 5, 0, 1};
  int          lp [4] = '{0, 1, 4, 5};

  gxp_top dut (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PIN_IN_I(PIN_IN_I), .PIN_OUT_O(PIN_OUT_O),
    .PIN_OE_O(PIN_OE_O), .PIN_PULLUP_O(PIN_PULLUP_O), .PDM1_I(PDM1_I), .PDM2_I(PDM2_I),
    .IRQ_O(IRQ_O), .PROG_CNT_EN_O(PROG_CNT_EN_O));
  gxp_pads pads (.clk_i(CLK_I), .out_i(PIN_OUT_O), .oe_i(PIN_OE_O), .pu_i(PIN_PULLUP_O),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(PIN_IN_I));

  // 100 MHz clock
  initial
  begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  // eight shifts per call so successive bytes are not mere shifts of each other
  function logic [7:0] rnd();
    for (int i = 0; i < 8; i++)
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge CLK_I);
    ADDR_I = a;
    WDATA_I = v;
    WR_I = 1'b1;
    @(negedge CLK_I);
    WR_I = 1'b0;
    // only implemented bits are kept, and nothing lands while the enable is low
    for (int i = 1; i < 8; i++)
      if (adr[i] == a && CE_I)
        model[a] = int'(v & msk[i]);
  endtask : wr

  task rdc(input string what, input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(negedge CLK_I);
    ADDR_I = a;
    RD_I = 1'b1;
    @(negedge CLK_I);
    RD_I = 1'b0;
    chk(what, exp & m, RDATA_O & m);
  endtask : rdc

  task stop_test();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // main sequence; pins held high from outside so no stray edges
  initial
  begin
    {RST_I, CE_I, WR_I, RD_I, PDM1_I, PDM2_I} = 6'h30;
    {ADDR_I, WDATA_I} = 16'h0000;
    {ext_en, ext_val} = 12'hfff;
    repeat (10) @(posedge CLK_I);
    @(negedge CLK_I);
    RST_I = 1'b0;
    for (int i = 0; i < 8; i++)
      rdc("reset value", adr[i], 8'h00, 8'hff);
    rdc("unmapped", 8'h3f, 8'h00, 8'hff);
    for (int k = 1; k < 15; k++)
    begin
      d = rnd();
      wr(adr[k % 7 + 1], d);
      rdc("readback", adr[k % 7 + 1], 8'(model[adr[k % 7 + 1]]), 8'hff);
    end
    // outputs from the latches, kept across other writes
    ext_en = 6'h00;
    wr(ADDR_P2_MODE, 8'h00);
    wr(ADDR_P2_DIRECTION, 8'hff);
    wr(ADDR_P3_DIRECTION, 8'h0f);
    e2 = rnd();
    e3 = rnd();
    wr(ADDR_P2_DATA, e2);
    wr(ADDR_P3_DATA, e3);
    chk("pin out", {2'h0, e3[1:0], e2[5], e2[2:0]}, {2'h0, PIN_OUT_O});
    chk("pin oe", 8'h3f, {2'h0, PIN_OE_O});
    rdc("p2 latch", ADDR_P2_DATA, e2, 8'hff);
    rdc("p3 latch", ADDR_P3_DATA, e3 & 8'h0f, 8'hff);
    wr(ADDR_P2_PULLUP, rnd());
    chk("pin hold", {2'h0, e3[1:0], e2[5], e2[2:0]}, {2'h0, PIN_OUT_O});
    // inputs: only bits with a defined pad level are compared
    wr(ADDR_P2_DIRECTION, 8'h00);
    wr(ADDR_P3_DIRECTION, 8'h00);
    repeat (6)
    begin
      g = rnd();
      wr(ADDR_P2_PULLUP, g);
      wr(ADDR_P3_PULLUP, g);
      d = rnd();
      ext_en = d[5:0];
      d = rnd();
      ext_val = d[5:0];
      repeat (3) @(negedge CLK_I);
      {e2, e3, m2, m3} = 32'h00000000;
      for (int i = 0; i < 6; i++)
        if (i < 4)
          {m2[pb[i]], e2[pb[i]]} = {ext_en[i] | g[pb[i]], ~ext_en[i] | ext_val[i]};
        else
          {m3[pb[i]], e3[pb[i]]} = {ext_en[i] | g[pb[i]], ~ext_en[i] | ext_val[i]};
      rdc("p2 input", ADDR_P2_DATA, e2, m2);
      rdc("p3 input", ADDR_P3_DATA, e3, m3);
    end
    // modulators take over their pins only while selected
    wr(ADDR_P2_MODE, 8'h30);
    repeat (4)
    begin
      d = rnd();
      @(negedge CLK_I);
      {PDM2_I, PDM1_I} = d[1:0];
      #1;
      chk("pdm pins", {4'h3, d[1:0]}, {2'h0, PIN_OE_O[3:2], PIN_OUT_O[3:2]});
    end
    wr(ADDR_P2_MODE, 8'h10);
    chk("pdm select", 8'h01, {6'h00, PIN_OE_O[3:2]});
    // clock enable low: a write must not land, so the model keeps the old value
    CE_I = 1'b0;
    wr(ADDR_P2_DIRECTION, 8'h5a);
    CE_I = 1'b1;
    rdc("ce freeze", ADDR_P2_DIRECTION, 8'(model[ADDR_P2_DIRECTION]), 8'hff);
    wr(ADDR_P3_MODE, 8'h10);
    chk("cnt out", 8'h01, {7'h00, PROG_CNT_EN_O});
    // every line, every trigger mode, a fall then a rise
    {ext_en, ext_val} = 12'hfff;
    for (int l = 0; l < 4; l++)
    begin
      wr(l < 2 ? ADDR_P2_DIRECTION : ADDR_P3_DIRECTION, 8'h00);
      wr(l < 2 ? ADDR_P2_PULLUP : ADDR_P3_PULLUP, 8'h01 << (l % 2));
      for (int m = 0; m < 4; m++)
      begin
        wr(l < 2 ? ADDR_P2_MODE : ADDR_P3_MODE, 8'(m << (2 * (l % 2))));
        for (int e = 0; e < 2; e++)
        begin
          g = rnd();
          wr(ADDR_IRQ_ENABLES, {g[7], 3'h0, g[0] ? 4'h1 << l : 4'h0});
          wr(ADDR_IRQ_PENDING, 8'h00);
          ext_val[lp[l]] = e[0];
          d = ((e == 1) ? (m != 0) : (m != 1)) ? 8'h01 << l : 8'h00;
          for (int t = 0; t < 8 && IRQ_O !== 1'b1; t++)
            @(negedge CLK_I);
          chk("irq", {7'h00, d != 0 && g[7] && g[0]}, {7'h00, IRQ_O});
          rdc("pending", ADDR_IRQ_PENDING, d, 8'hff);
          wr(ADDR_IRQ_PENDING, 8'h00);
          rdc("cleared", ADDR_IRQ_PENDING, 8'h00, 8'hff);
        end
      end
    end
    stop_test();
  end
endmodule : test_gxp_top

`default_nettype wire
